/* File: pkg/tgio_pkg.sv */
// Purpose: shared constants for the timer pin function control block
// Assumes: one clock domain, 8-bit control registers on a plain port
// Notes:   register indices are word indices on the plain port
package tgio_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADDR_W          = 3;
    localparam logic [2:0]  IDX_CH0_HIGH    = 3'h0;
    localparam logic [2:0]  IDX_CH0_LOW     = 3'h1;
    localparam logic [2:0]  IDX_CH1         = 3'h2;
    localparam logic [2:0]  IDX_CH2         = 3'h3;
    localparam logic [2:0]  IDX_PIN_OUT     = 3'h4;
    localparam logic [2:0]  IDX_PIN_IN      = 3'h5;

    localparam int unsigned DATA_W          = 8;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  CH0_WRITE_MASK  = 8'h7f;
    localparam logic [7:0]  FULL_WRITE_MASK = 8'hff;
    localparam logic [7:0]  READ_ZERO       = 8'h00;

    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam int unsigned FIELD_W   = 4;
    localparam int unsigned LO_LSB    = 0;
    localparam int unsigned HI_LSB    = 4;
    localparam int unsigned BIT_INIT  = 2;
    localparam int unsigned BIT_MODE  = 3;
    localparam int unsigned BIT_CNT   = 2;

    // ****************************************************************
    // field codes
    // ****************************************************************
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] CAP_RISE   = 2'h0;
    localparam logic [1:0] CAP_FALL   = 2'h1;
    localparam logic [1:0] CAP_BOTH   = 2'h2;

    // ****************************************************************
    // general register slots
    // ****************************************************************
    localparam int unsigned NUM_UNITS = 8;
    localparam int unsigned U_CH0_A   = 0;
    localparam int unsigned U_CH0_B   = 1;
    localparam int unsigned U_CH0_C   = 2;
    localparam int unsigned U_CH0_D   = 3;
    localparam int unsigned U_CH1_A   = 4;
    localparam int unsigned U_CH1_B   = 5;
    localparam int unsigned U_CH2_A   = 6;
    localparam int unsigned U_CH2_B   = 7;

endpackage

/* File: verilog/tgio_pin_sync.sv */
// Purpose: three-stage synchroniser and edge finder for one timer pin
// Assumes: pin is asynchronous to clk
// Notes:   a change counts once stages two and three agree
module tgio_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_async,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic rise_reg;
    logic fall_reg;

    // ****************************************************************
    // sampling chain
    // ****************************************************************
    // the first stage feeds only the second, to keep metastability out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ****************************************************************
    // accepted level and edges
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end else begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            if (s2_reg == s3_reg && s3_reg != level_reg) begin
                level_reg <= s3_reg;
                rise_reg  <= s3_reg;
                fall_reg  <= ~s3_reg;
            end
        end
    end

    assign level = level_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;

endmodule

/* File: verilog/tgio_top.sv */
// Purpose: pin function control registers of a three-channel timer
// Assumes: counter, compare match and capture load live outside
// Notes:   capture strobes tell the outside which register to load
module tgio_top #(
    parameter int unsigned NUM_UNITS = tgio_pkg::NUM_UNITS
) (
    input  wire logic                        CLK_SYS,
    input  wire logic                        RESET_N,
    input  wire logic [tgio_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic [tgio_pkg::DATA_W-1:0] REG_WDATA,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    output logic      [tgio_pkg::DATA_W-1:0] REG_RDATA,
    input  wire logic [NUM_UNITS-1:0]        COMPARE_MATCH,
    input  wire logic                        CHAN1_COUNT_STEP,
    input  wire logic                        BUF_MODE_A,
    input  wire logic                        BUF_MODE_B,
    input  wire logic [NUM_UNITS-1:0]        PIN_IN,
    output logic      [NUM_UNITS-1:0]        PIN_OUT,
    output logic      [NUM_UNITS-1:0]        PIN_OE_N,
    output logic      [NUM_UNITS-1:0]        CAPTURE_STROBE
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the slot map is fixed at eight general registers
    if (NUM_UNITS != tgio_pkg::NUM_UNITS) begin : g_bad_units
        $error("tgio_top supports exactly eight general registers");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [7:0]                  ch0_high_reg;
    logic [7:0]                  ch0_low_reg;
    logic [7:0]                  ch1_reg;
    logic [7:0]                  ch2_reg;
    logic [7:0]                  rdata_reg;
    logic [7:0]                  rdata_next;
    logic                        wr_ch0_high;
    logic                        wr_ch0_low;
    logic                        wr_ch1;
    logic                        wr_ch2;
    logic [tgio_pkg::FIELD_W-1:0] field [NUM_UNITS];
    logic [NUM_UNITS-1:0]        field_load;
    logic [NUM_UNITS-1:0]        unit_enable;
    logic [NUM_UNITS-1:0]        pin_level;
    logic [NUM_UNITS-1:0]        pin_rise;
    logic [NUM_UNITS-1:0]        pin_fall;
    logic [NUM_UNITS-1:0]        pin_out_reg;
    logic [NUM_UNITS-1:0]        pin_oe_n_reg;
    logic [NUM_UNITS-1:0]        capture_reg;

    // ****************************************************************
    // write decode
    // ****************************************************************
    assign wr_ch0_high = REG_WR && (REG_ADDR == tgio_pkg::IDX_CH0_HIGH);
    assign wr_ch0_low  = REG_WR && (REG_ADDR == tgio_pkg::IDX_CH0_LOW);
    assign wr_ch1      = REG_WR && (REG_ADDR == tgio_pkg::IDX_CH1);
    assign wr_ch2      = REG_WR && (REG_ADDR == tgio_pkg::IDX_CH2);

    // ****************************************************************
    // channel 0 high byte
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ch0_high_reg <= tgio_pkg::CTRL_RESET;
        end else if (wr_ch0_high) begin
            // bit 7 is held at zero whatever software writes
            ch0_high_reg <= REG_WDATA & tgio_pkg::CH0_WRITE_MASK;
        end
    end

    // ****************************************************************
    // channel 0 low byte
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ch0_low_reg <= tgio_pkg::CTRL_RESET;
        end else if (wr_ch0_low) begin
            ch0_low_reg <= REG_WDATA & tgio_pkg::CH0_WRITE_MASK;
        end
    end

    // ****************************************************************
    // channel 1 and 2 bytes
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ch1_reg <= tgio_pkg::CTRL_RESET;
        end else if (wr_ch1) begin
            ch1_reg <= REG_WDATA & tgio_pkg::FULL_WRITE_MASK;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ch2_reg <= tgio_pkg::CTRL_RESET;
        end else if (wr_ch2) begin
            ch2_reg <= REG_WDATA & tgio_pkg::FULL_WRITE_MASK;
        end
    end

    // ****************************************************************
    // field extraction
    // ****************************************************************
    // three-bit fields are widened with a zero top bit, so they can
    // only ever select compare functions
    assign field[tgio_pkg::U_CH0_A] = ch0_high_reg[tgio_pkg::LO_LSB +: 4];
    assign field[tgio_pkg::U_CH0_B] = {1'b0, ch0_high_reg[tgio_pkg::HI_LSB +: 3]};
    assign field[tgio_pkg::U_CH0_C] = ch0_low_reg[tgio_pkg::LO_LSB +: 4];
    assign field[tgio_pkg::U_CH0_D] = {1'b0, ch0_low_reg[tgio_pkg::HI_LSB +: 3]};
    assign field[tgio_pkg::U_CH1_A] = ch1_reg[tgio_pkg::LO_LSB +: 4];
    assign field[tgio_pkg::U_CH1_B] = ch1_reg[tgio_pkg::HI_LSB +: 4];
    assign field[tgio_pkg::U_CH2_A] = ch2_reg[tgio_pkg::LO_LSB +: 4];
    assign field[tgio_pkg::U_CH2_B] = ch2_reg[tgio_pkg::HI_LSB +: 4];

    // a write reloads the initial level of both fields in that byte
    assign field_load[tgio_pkg::U_CH0_A] = wr_ch0_high;
    assign field_load[tgio_pkg::U_CH0_B] = wr_ch0_high;
    assign field_load[tgio_pkg::U_CH0_C] = wr_ch0_low;
    assign field_load[tgio_pkg::U_CH0_D] = wr_ch0_low;
    assign field_load[tgio_pkg::U_CH1_A] = wr_ch1;
    assign field_load[tgio_pkg::U_CH1_B] = wr_ch1;
    assign field_load[tgio_pkg::U_CH2_A] = wr_ch2;
    assign field_load[tgio_pkg::U_CH2_B] = wr_ch2;

    // ****************************************************************
    // buffer mode gating
    // ****************************************************************
    // register C acts purely as a buffer in buffer mode A, register D in buffer mode B
    always_comb begin
        unit_enable = '1;
        unit_enable[tgio_pkg::U_CH0_C] = ~BUF_MODE_A;
        unit_enable[tgio_pkg::U_CH0_D] = ~BUF_MODE_B;
    end

    // ****************************************************************
    // per general register logic
    // ****************************************************************
    for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
        // odd slots hold upper-nibble fields, even slots lower-nibble ones
        localparam int unsigned WR_LSB = (i % 2 == 1) ? tgio_pkg::HI_LSB : tgio_pkg::LO_LSB;
        logic       is_capture;
        logic [1:0] action;
        logic       drive_on;

        assign is_capture = field[i][tgio_pkg::BIT_MODE];
        assign action     = field[i][1:0];
        assign drive_on   = unit_enable[i] && !is_capture
                            && (action != tgio_pkg::ACT_NONE);

        tgio_pin_sync u_sync (
            .clk       (CLK_SYS),
            .rst_n     (RESET_N),
            .pin_async (PIN_IN[i]),
            .level     (pin_level[i]),
            .rise      (pin_rise[i]),
            .fall      (pin_fall[i])
        );

        // compare output level; a control write wins over a match
        // in the same cycle, so software sees its initial level
        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                pin_out_reg[i] <= 1'b0;
            end else if (field_load[i]) begin
                // the field register updates on this same edge, so take the new byte
                pin_out_reg[i] <= REG_WDATA[WR_LSB + tgio_pkg::BIT_INIT];
            end else if (drive_on && COMPARE_MATCH[i]) begin
                unique case (action)
                    tgio_pkg::ACT_LOW: begin
                        pin_out_reg[i] <= 1'b0;
                    end
                    tgio_pkg::ACT_HIGH: begin
                        pin_out_reg[i] <= 1'b1;
                    end
                    tgio_pkg::ACT_TOGGLE: begin
                        pin_out_reg[i] <= ~pin_out_reg[i];
                    end
                    tgio_pkg::ACT_NONE: begin
                        pin_out_reg[i] <= pin_out_reg[i];
                    end
                endcase
            end
        end

        // pin is released while output is disabled or capturing
        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                pin_oe_n_reg[i] <= 1'b1;
            end else begin
                pin_oe_n_reg[i] <= ~drive_on;
            end
        end

        // capture strobe, one cycle per accepted event
        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                capture_reg[i] <= 1'b0;
            end else if (!unit_enable[i] || !is_capture) begin
                capture_reg[i] <= 1'b0;
            end else if (field[i][tgio_pkg::BIT_CNT]) begin
                capture_reg[i] <= CHAN1_COUNT_STEP;
            end else begin
                unique case (action)
                    tgio_pkg::CAP_RISE: begin
                        capture_reg[i] <= pin_rise[i];
                    end
                    tgio_pkg::CAP_FALL: begin
                        capture_reg[i] <= pin_fall[i];
                    end
                    tgio_pkg::CAP_BOTH: begin
                        capture_reg[i] <= pin_rise[i] | pin_fall[i];
                    end
                    default: begin
                        // unassigned capture code: no capture
                        capture_reg[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb begin
        rdata_next = tgio_pkg::READ_ZERO;
        unique case (REG_ADDR)
            tgio_pkg::IDX_CH0_HIGH: begin
                rdata_next = ch0_high_reg;
            end
            tgio_pkg::IDX_CH0_LOW: begin
                rdata_next = ch0_low_reg;
            end
            tgio_pkg::IDX_CH1: begin
                rdata_next = ch1_reg;
            end
            tgio_pkg::IDX_CH2: begin
                rdata_next = ch2_reg;
            end
            tgio_pkg::IDX_PIN_OUT: begin
                rdata_next = pin_out_reg;
            end
            tgio_pkg::IDX_PIN_IN: begin
                rdata_next = pin_level;
            end
            default: begin
                // unmapped index reads as zero
                rdata_next = tgio_pkg::READ_ZERO;
            end
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= tgio_pkg::READ_ZERO;
        end else if (REG_RD) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= tgio_pkg::READ_ZERO;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign REG_RDATA      = rdata_reg;
    assign PIN_OUT        = pin_out_reg;
    assign PIN_OE_N       = pin_oe_n_reg;
    assign CAPTURE_STROBE = capture_reg;

endmodule

/* File: test/tgio_checker.sv */
// Purpose: port checker for the timer pin function control block
// Assumes: one clock; shadow bytes follow the register writes
// Notes:   watches slots 0, 2, 4 only, to stay small
module tgio_checker #(
    parameter int unsigned NUM_UNITS = 8
) (
    input wire logic                        CLK_SYS,
    input wire logic                        RESET_N,
    input wire logic [tgio_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tgio_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic                        REG_WR,
    input wire logic                        REG_RD,
    input wire logic [tgio_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic [NUM_UNITS-1:0]        COMPARE_MATCH,
    input wire logic                        CHAN1_COUNT_STEP,
    input wire logic                        BUF_MODE_A,
    input wire logic                        BUF_MODE_B,
    input wire logic [NUM_UNITS-1:0]        PIN_IN,
    input wire logic [NUM_UNITS-1:0]        PIN_OUT,
    input wire logic [NUM_UNITS-1:0]        PIN_OE_N,
    input wire logic [NUM_UNITS-1:0]        CAPTURE_STROBE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // shadow bytes and properties
    // ****************************************************************
    logic [7:0] ch0h_reg;
    logic [7:0] ch1_reg;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ch0h_reg <= 8'h00;
            ch1_reg  <= 8'h00;
        end else if (REG_WR && REG_ADDR == tgio_pkg::IDX_CH0_HIGH) begin
            ch0h_reg <= REG_WDATA & 8'h7f;
        end else if (REG_WR && REG_ADDR == tgio_pkg::IDX_CH1) begin
            ch1_reg <= REG_WDATA;
        end
    end

    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside a read");
    rsvd_bit_a: assert property ($past(REG_RD) && $past(REG_ADDR) <= 3'h1 |-> !REG_RDATA[7])
        else $error("reserved bit reads one");
    oe_on_a: assert property ($stable(ch1_reg) && !ch1_reg[3] && ch1_reg[1:0] != 2'h0 |-> !PIN_OE_N[4])
        else $error("compare output not driven");
    oe_off_a: assert property ($stable(ch1_reg) && ch1_reg[1:0] == 2'h0 |-> PIN_OE_N[4])
        else $error("disabled output driven");
    act_low_a: assert property (COMPARE_MATCH[4] && !REG_WR && ch1_reg[3:0] inside {4'h1, 4'h5}
        |-> ##1 !PIN_OUT[4]) else $error("match did not drive low");
    act_high_a: assert property (COMPARE_MATCH[4] && !REG_WR && ch1_reg[3:0] inside {4'h2, 4'h6}
        |-> ##1 PIN_OUT[4]) else $error("match did not drive high");
    act_toggle_a: assert property (COMPARE_MATCH[4] && !REG_WR && ch1_reg[3:0] inside {4'h3, 4'h7}
        |-> ##1 PIN_OUT[4] != $past(PIN_OUT[4])) else $error("match did not toggle");
    step_cap_a: assert property (CHAN1_COUNT_STEP && !REG_WR && ch1_reg[3:2] == 2'h3
        |-> ##1 CAPTURE_STROBE[4]) else $error("count step not captured");
    pin_cap_a: assert property ((($rose(PIN_IN[0]) && ch0h_reg[3:0] != 4'h9)
        || ($fell(PIN_IN[0]) && ch0h_reg[3:0] != 4'h8)) && ch0h_reg[3:2] == 2'h2 && ch0h_reg[1:0] != 2'h3
        |-> ##[3:6] CAPTURE_STROBE[0]) else $error("pin edge not captured");
    buf_off_a: assert property (BUF_MODE_A && $past(BUF_MODE_A) |-> PIN_OE_N[2] && !CAPTURE_STROBE[2])
        else $error("buffer slot still active");

    cover property (CAPTURE_STROBE[0]);
    cover property (COMPARE_MATCH[4] && !PIN_OE_N[4]);
    cover property (BUF_MODE_A && CHAN1_COUNT_STEP);
endmodule

/* File: test/tgio_pin_model.sv */
// Purpose: outside world of the eight timer pins
// Assumes: the device wins when both sides drive
// Notes:   an undriven pin falls to its pull-down
module tgio_pin_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // wire resolution
    // ****************************************************************
    // a released pin that the outside does not drive must not keep a stale level, so fall to the pull-down
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_level[i];
            end else begin
                pin_level[i] = 1'b0;
            end
        end
    end
endmodule

/* File: test/tgio_tb_top.sv */
// Purpose: self-checking bench for the timer pin function control block
// Assumes: all stimulus on the rising edge by non-blocking assignment
// Notes:   slots 4 and 5 carry the compare walk, slot 0 the pin capture
module tgio_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals, design and partner
    // ****************************************************************
    logic                        clk_sys;
    logic                        reset_n;
    logic [tgio_pkg::ADDR_W-1:0] reg_addr;
    logic [7:0]                  reg_wdata;
    logic                        reg_wr;
    logic                        reg_rd;
    logic [7:0]                  reg_rdata;
    logic [7:0]                  cmp_match;
    logic                        step;
    logic                        buf_a;
    logic                        buf_b;
    logic [7:0]                  pin_in;
    logic [7:0]                  pin_out;
    logic [7:0]                  pin_oe_n;
    logic [7:0]                  cap;
    logic [7:0]                  ext_en;
    logic [7:0]                  ext_level;
    int                          errors;
    int                          n_checks;

    tgio_top dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .COMPARE_MATCH(cmp_match),
        .CHAN1_COUNT_STEP(step), .BUF_MODE_A(buf_a), .BUF_MODE_B(buf_b), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .CAPTURE_STROBE(cap));
    tgio_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_level(ext_level),
        .pin_level(pin_in));

    // ****************************************************************
    // bus and check tasks
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic step_pulse(input logic [7:0] exp);
        @(posedge clk_sys);
        step <= 1'b1;
        @(posedge clk_sys);
        step <= 1'b0;
        #1 check(cap, exp, "count step capture");
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic regs_test();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            reg_read(3'(i), d);
            check(d, 8'h00, "reset value");
            reg_write(3'(i), 8'hff);
            reg_read(3'(i), d);
            check(d, (i < 2) ? 8'h7f : 8'hff, "write mask");
        end
        reg_write(3'h6, 8'h5a);
        reg_read(3'h6, d);
        check(d, 8'h00, "unmapped read");
        for (int i = 0; i < 4; i++) reg_write(3'(i), 8'h00);
    endtask
    task automatic compare_test();
        logic [3:0] f;
        logic       e;
        logic [7:0] d;
        for (int k = 0; k < 8; k++) begin
            f = 4'(k);
            reg_write(tgio_pkg::IDX_CH1, {f, f});
            ticks(2);
            check(8'(pin_oe_n[5:4]), (f[1:0] == 2'h0) ? 8'h03 : 8'h00, "output enable");
            check(8'(pin_out[5:4]), f[2] ? 8'h03 : 8'h00, "initial level");
            e = (f[1:0] == 2'h0) ? f[2] : (f[1:0] == 2'h3) ? ~f[2] : f[1];
            @(posedge clk_sys);
            cmp_match <= 8'h30;
            @(posedge clk_sys);
            cmp_match <= 8'h00;
            #1;
            check(8'(pin_out[5:4]), {6'h00, e, e}, "match action");
            reg_read(tgio_pkg::IDX_PIN_OUT, d);
            check(d & 8'h30, {2'h0, e, e, 4'h0}, "pin level readback");
            ticks(2);
            reg_read(tgio_pkg::IDX_PIN_IN, d);
            check(d & 8'h30, (f[1:0] == 2'h0) ? 8'h00 : {2'h0, e, e, 4'h0}, "pin sense readback");
        end
    endtask
    task automatic capture_test();
        logic [3:0] code;
        int         n;
        for (int k = 8; k < 12; k++) begin
            code = 4'(k);
            reg_write(tgio_pkg::IDX_CH0_HIGH, {4'h0, code});
            for (int e = 0; e < 2; e++) begin
                @(posedge clk_sys);
                ext_level[0] <= (e == 0);
                n = 0;
                // the window covers the synchroniser and edge stages with margin
                repeat (10) begin
                    @(posedge clk_sys);
                    #1 if (cap[0] === 1'b1) n++;
                end
                check(8'(n), (code == 4'ha || code == 4'(8 + e)) ? 8'h01 : 8'h00, "pin capture");
            end
        end
    endtask
    task automatic step_test();
        reg_write(tgio_pkg::IDX_CH1, 8'hcc);
        reg_write(tgio_pkg::IDX_CH0_LOW, 8'h3c);
        ticks(2);
        check(8'(pin_oe_n[3]), 8'h00, "reg d output");
        step_pulse(8'h34);
        @(posedge clk_sys);
        buf_a <= 1'b1;
        buf_b <= 1'b1;
        ticks(2);
        check(8'(pin_oe_n[3]), 8'h01, "buffered reg d output");
        step_pulse(8'h30);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        reset_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmp_match = 8'h00;
        step = 1'b0;
        buf_a = 1'b0;
        buf_b = 1'b0;
        ext_en = 8'hff;
        ext_level = 8'h00;
        errors = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        regs_test();
        compare_test();
        capture_test();
        step_test();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        conclude();
    end
endmodule

bind tgio_top tgio_checker #(.NUM_UNITS(NUM_UNITS)) u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .COMPARE_MATCH(COMPARE_MATCH), .CHAN1_COUNT_STEP(CHAN1_COUNT_STEP), .BUF_MODE_A(BUF_MODE_A),
    .BUF_MODE_B(BUF_MODE_B), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
    .CAPTURE_STROBE(CAPTURE_STROBE));
